// File: ctrl_channel_pkg.sv
// Constants, states and helpers shared by the control-channel block.
// Assumes strap pins arrive already resolved to level indices by the pad logic.
`default_nettype none
package ctrl_channel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Slave address strapping
  localparam logic [6:0] SER_ADDR_BASE = 7'h58;
  localparam logic [2:0] SER_STRAP_MAX = 3'h5;
  localparam logic [6:0] DES_ADDR_BASE = 7'h60;

  ////////////////////////////////////////////////////////////////////////////
  // Local register pointers reached through the slave port
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_GPIO_VALUE  = 8'h01;
  localparam logic [7:0] REG_GPIO_SELECT = 8'h02;
  localparam logic [7:0] REG_STATUS      = 8'h03;
  localparam int         CTRL_PASS_BIT   = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [3:0] GPIO_VAL_RESET  = 4'h0;
  localparam logic [3:0] GPIO_SEL_RESET  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Pins taken over in oscillator reference mode, and bits per byte
  localparam int         OSC_IN_PIN      = 3;
  localparam int         OSC_DIV_PIN     = 2;
  localparam logic [3:0] OSC_LOCAL_MASK  = 4'hc;
  localparam logic [3:0] BYTE_BITS       = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Slave byte engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_RX   = 7'h04,
    ST_WAIT = 7'h08,
    ST_ACK  = 7'h10,
    ST_TX   = 7'h20,
    ST_MACK = 7'h40
  } slave_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers
  function automatic logic [6:0] ser_slave_addr(input logic [2:0] level);
    logic [2:0] idx;
    idx = (level > SER_STRAP_MAX) ? SER_STRAP_MAX : level;
    return SER_ADDR_BASE + {4'h0, idx};
  endfunction : ser_slave_addr

  function automatic logic [6:0] des_slave_addr(input logic [1:0] high, input logic [1:0] low);
    return DES_ADDR_BASE + {3'h0, high, low};
  endfunction : des_slave_addr

  function automatic logic [7:0] write_form(input logic [6:0] addr);
    return {addr, 1'b0};
  endfunction : write_form

endpackage : ctrl_channel_pkg
`default_nettype wire

// File: level_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; bundles are not sampled coherently.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync
`default_nettype wire

// File: ctrl_channel_addr_gpio.sv
// Slave port, pass-through relay gating, strap addressing and GPIO tunnelling.
// Assumes link-side relay logic runs on clock; pins and link clock are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - With pass-through on, foreign-address bytes are relayed across the link.
// - With pass-through off, foreign transactions stay local and are never relayed.
// - Serializer strap level 0..5 gives addresses 0x58..0x5D.
// - Deserializer straps high/low pick index bits 3:2/1:0, addresses 0x60..0x6F.
// - Write-form address is 7-bit address shifted left with zero appended.
// - Built-in slave controller configures registers and controls GPIO pins.
// - Pixel-clock mode gives four general-purpose pins on each end.
// - Serializer output shows forwarded remote level or local register bit.
// - Deserializer pin is forwarded input or local register-driven output.
// - Oscillator mode: serializer pin 3 becomes input, pin 2 outputs half clock.
// - Oscillator mode: deserializer pins 2 and 3 are local outputs, never forwarded.
// - Forwarded pins carry toggles up to 66 kHz; sources stay below that.
// - Forwarded edges reach parallel remote outputs within 25 us of each other.
// - Relayed bytes stretch SCL low on the ninth clock until remote answers.
module ctrl_channel_addr_gpio
  import ctrl_channel_pkg::*;
#(
  parameter bit IS_DES     = 1'b0,
  parameter int GPIO_COUNT = 4
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Local I2C bus, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps and reference mode
  input  wire logic [2:0] ser_address_strap,
  input  wire logic [1:0] des_address_strap_low,
  input  wire logic [1:0] des_address_strap_high,
  input  wire logic       osc_ref_mode,
  // Relay towards the remote bus
  output logic            relay_valid,
  output logic [7:0]      relay_data,
  output logic            relay_first,
  output logic            relay_read,
  output logic            relay_stop,
  input  wire logic       relay_done,
  input  wire logic       relay_ack,
  input  wire logic [7:0] relay_rdata,
  // Link GPIO tunnel
  input  wire logic       link_clk,
  input  wire logic [3:0] link_gpio_in,
  output logic [3:0]      link_gpio_out,
  // General-purpose pins
  input  wire logic [3:0] gpio_in,
  output logic [3:0]      gpio_out,
  output logic [3:0]      gpio_oe,
  // Status
  output logic [7:0]      own_write_addr,
  output logic            pass_through_on
);

  initial begin
    if (GPIO_COUNT != 4) $error("ctrl_channel_addr_gpio: GPIO_COUNT must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [18:0] sync_w;
  logic        scl_n_s, sda_n_s, lclk_s, osc_s;
  logic [2:0]  ser_strap_s;
  logic [1:0]  des_low_s, des_high_s;
  logic [3:0]  fwd_in_s, pin_s;

  level_sync #(.WIDTH(19)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({~scl_in, ~sda_in, link_clk, osc_ref_mode, ser_address_strap,
                des_address_strap_low, des_address_strap_high, link_gpio_in, gpio_in}),
    .sync_out (sync_w)
  );

  // Bus lines enter inverted so the reset value reads as idle high
  assign {scl_n_s, sda_n_s, lclk_s, osc_s, ser_strap_s, des_low_s, des_high_s,
          fwd_in_s, pin_s} = sync_w;

  wire logic scl_s = ~scl_n_s;
  wire logic sda_s = ~sda_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Own address
  wire logic [6:0] ser_addr_w = ser_slave_addr(ser_strap_s);
  wire logic [6:0] des_addr_w = des_slave_addr(des_high_s, des_low_s);
  wire logic [6:0] own_addr_w = IS_DES ? des_addr_w : ser_addr_w;

  ////////////////////////////////////////////////////////////////////////////
  // Bus event detection
  logic scl_q_r, sda_q_r, lclk_q_r, osc_q_r;

  wire logic scl_rise  = scl_s & ~scl_q_r;
  wire logic scl_fall  = ~scl_s & scl_q_r;
  wire logic bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire logic bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  wire logic lclk_rise = lclk_s & ~lclk_q_r;
  wire logic osc_rise  = pin_s[OSC_IN_PIN] & ~osc_q_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      lclk_q_r <= 1'b0;
      osc_q_r  <= 1'b0;
    end else begin
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      lclk_q_r <= lclk_s;
      osc_q_r  <= pin_s[OSC_IN_PIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local registers and their read view
  logic [7:0]   ctrl_r, ptr_r, shift_r;
  logic [3:0]   gval_r, gsel_r, bit_cnt_r;
  logic         local_r, rw_r, first_r, ack_r, data_phase_r;
  slave_state_t state_r;

  wire logic       pass_en    = ctrl_r[CTRL_PASS_BIT];
  wire logic       byte_done  = scl_fall & (bit_cnt_r == BYTE_BITS);
  wire logic       addr_match = (shift_r[7:1] == own_addr_w);
  wire logic [7:0] local_rd   =
      (ptr_r == REG_CTRL)        ? ctrl_r :
      (ptr_r == REG_GPIO_VALUE)  ? {4'h0, gval_r} :
      (ptr_r == REG_GPIO_SELECT) ? {4'h0, gsel_r} :
      (ptr_r == REG_STATUS)      ? {pin_s, osc_s, 3'h0} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Slave byte engine
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= ST_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      local_r      <= 1'b0;
      rw_r         <= 1'b0;
      first_r      <= 1'b0;
      ack_r        <= 1'b0;
      data_phase_r <= 1'b0;
      ptr_r        <= 8'h00;
      ctrl_r       <= CTRL_RESET;
      gval_r       <= GPIO_VAL_RESET;
      gsel_r       <= GPIO_SEL_RESET;
      relay_valid  <= 1'b0;
      relay_data   <= 8'h00;
      relay_first  <= 1'b0;
      relay_read   <= 1'b0;
      relay_stop   <= 1'b0;
    end else begin
      relay_valid <= 1'b0;
      relay_stop  <= 1'b0;
      if (bus_start) begin
        state_r      <= ST_ADDR;
        bit_cnt_r    <= 4'h0;
        data_phase_r <= 1'b0;
      end else if (bus_stop) begin
        relay_stop   <= ~local_r & data_phase_r;
        data_phase_r <= 1'b0;
        state_r      <= ST_IDLE;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (byte_done && state_r == ST_ADDR && addr_match) begin
              local_r      <= 1'b1;
              rw_r         <= shift_r[0];
              first_r      <= 1'b1;
              ack_r        <= 1'b1;
              data_phase_r <= 1'b1;
              state_r      <= ST_ACK;
            end else if (byte_done && state_r == ST_ADDR && pass_en) begin
              local_r      <= 1'b0;
              rw_r         <= shift_r[0];
              data_phase_r <= 1'b1;
              relay_valid  <= 1'b1;
              relay_data   <= shift_r;
              relay_first  <= 1'b1;
              relay_read   <= 1'b0;
              state_r      <= ST_WAIT;
            end else if (byte_done && state_r == ST_ADDR) begin
              state_r <= ST_IDLE;
            end else if (byte_done && local_r) begin
              first_r <= 1'b0;
              ack_r   <= 1'b1;
              state_r <= ST_ACK;
              if (first_r) begin
                ptr_r <= shift_r;
              end else begin
                ptr_r <= ptr_r + 8'h01;
                if (ptr_r == REG_CTRL) ctrl_r <= shift_r;
                if (ptr_r == REG_GPIO_VALUE) gval_r <= shift_r[3:0];
                if (ptr_r == REG_GPIO_SELECT) gsel_r <= shift_r[3:0];
              end
            end else if (byte_done) begin
              relay_valid <= 1'b1;
              relay_data  <= shift_r;
              relay_first <= 1'b0;
              relay_read  <= 1'b0;
              state_r     <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (relay_done) begin
              ack_r   <= relay_read ? 1'b1 : relay_ack;
              shift_r <= relay_rdata;
              state_r <= (rw_r && relay_read) ? ST_TX : ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (!ack_r) begin
                state_r <= ST_IDLE;
              end else if (rw_r && local_r) begin
                shift_r <= local_rd;
                ptr_r   <= ptr_r + 8'h01;
                state_r <= ST_TX;
              end else if (rw_r) begin
                relay_valid <= 1'b1;
                relay_first <= 1'b0;
                relay_read  <= 1'b1;
                state_r     <= ST_WAIT;
              end else begin
                state_r <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              shift_r   <= {shift_r[6:0], 1'b1};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == BYTE_BITS - 4'h1) state_r <= ST_MACK;
            end
          end
          ST_MACK: begin
            // Echoing a master ACK low is harmless on the wired-AND line
            if (scl_rise) begin
              ack_r   <= ~sda_s;
              state_r <= ST_ACK;
            end
          end
        endcase
      end
    end
  end

  // Open-drain drive: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = (state_r == ST_WAIT);
  assign sda_oe  = ((state_r == ST_ACK) & ack_r) | ((state_r == ST_TX) & ~shift_r[7]);
  assign own_write_addr  = write_form(own_addr_w);
  assign pass_through_on = pass_en;

  ////////////////////////////////////////////////////////////////////////////
  // GPIO tunnelling
  logic       div_r;
  logic [3:0] gout_r, goe_r, link_out_r;

  wire logic [3:0] osc_mask   = osc_s ? OSC_LOCAL_MASK : 4'h0;
  wire logic [3:0] des_oe_w   = gsel_r | osc_mask;
  wire logic [3:0] des_fwd_w  = pin_s & ~des_oe_w;
  wire logic [3:0] ser_mux_w  = (gsel_r & gval_r) | (~gsel_r & fwd_in_s);
  wire logic [3:0] ser_out_w  = osc_s ? {1'b0, div_r, ser_mux_w[1:0]} : ser_mux_w;
  wire logic [3:0] ser_oe_w   = osc_s ? 4'h7 : 4'hf;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_r      <= 1'b0;
      gout_r     <= 4'h0;
      goe_r      <= 4'h0;
      link_out_r <= 4'h0;
    end else begin
      if (osc_s && osc_rise) div_r <= ~div_r;
      gout_r <= IS_DES ? gval_r : ser_out_w;
      goe_r  <= IS_DES ? des_oe_w : ser_oe_w;
      if (lclk_rise) link_out_r <= IS_DES ? des_fwd_w : 4'h0;
    end
  end

  assign gpio_out      = gout_r;
  assign gpio_oe       = goe_r;
  assign link_gpio_out = link_out_r;

endmodule : ctrl_channel_addr_gpio
`default_nettype wire

// File: ctrl_channel_addr_gpio_chk.sv
// Port checker for the control-channel block.
// Assumes straps and mode pins move slowly against clock.
`timescale 1ns/1ps
`default_nettype none
module ctrl_channel_addr_gpio_chk #(
  parameter bit IS_DES = 1'b0
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // Watched ports
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic [2:0] ser_address_strap,
  input wire logic       osc_ref_mode,
  input wire logic       relay_valid,
  input wire logic       relay_stop,
  input wire logic       relay_done,
  input wire logic [3:0] link_gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [7:0] own_write_addr,
  input wire logic       pass_through_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic [2:0] lvl = (ser_address_strap > 3'h5) ? 3'h5 : ser_address_strap;
  sequence strap_held; $stable(ser_address_strap) [*3]; endsequence
  sequence osc_held; osc_ref_mode [*5]; endsequence
  ////////////////////////////////////////
  drive_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain drive value not low");
  relay_pulse_a: assert property (relay_valid |=> !relay_valid)
    else $error("relay request longer than one cycle");
  pass_gate_a: assert property (relay_valid |-> pass_through_on)
    else $error("relay with pass-through off");
  stretch_start_a: assert property (relay_valid |-> scl_oe)
    else $error("relay without clock stretch");
  stretch_end_a: assert property ($fell(scl_oe) |-> $past(relay_done))
    else $error("stretch released before remote answer");
  strap_addr_a: assert property (strap_held |-> IS_DES ||
    own_write_addr == {7'h58 + {4'h0, lvl}, 1'b0}) else $error("own address wrong");
  osc_pins_a: assert property (osc_held |-> IS_DES || gpio_oe == 4'h7)
    else $error("oscillator mode pin enables wrong");
  des_osc_a: assert property (osc_held |-> !IS_DES || gpio_oe[3:2] == 2'b11)
    else $error("oscillator mode deserializer pins not local");
  stop_pulse_a: assert property (relay_stop |=> !relay_stop)
    else $error("relay stop longer than one cycle");
  link_quiet_a: assert property (!IS_DES |-> link_gpio_out == 4'h0)
    else $error("serializer forwards pin levels");
endmodule : ctrl_channel_addr_gpio_chk
bind ctrl_channel_addr_gpio ctrl_channel_addr_gpio_chk #(.IS_DES(IS_DES)) chk (
  .clock, .reset_n, .scl_out, .scl_oe, .sda_out, .ser_address_strap, .osc_ref_mode,
  .relay_valid, .relay_stop, .relay_done, .link_gpio_out, .gpio_oe, .own_write_addr,
  .pass_through_on);
`default_nettype wire

// File: i2c_host_model.sv
// Behavioural I2C master on the local bus, open drain.
// Assumes the bench resolves wire levels with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Clock and wire levels
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  // Pull-downs
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  task automatic tick();
    repeat (8) @(negedge clock);
  endtask : tick
  // Release clock, wait out any stretch
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(negedge clock);
    tick();
  endtask : rise
  task automatic start();
    sda_low = 1'b1;
    tick();
    scl_low = 1'b1;
    tick();
  endtask : start
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      tick();
      rise();
      scl_low = 1'b1;
      tick();
    end
    sda_low = 1'b0;
    tick();
    rise();
    ack = ~sda;
    scl_low = 1'b1;
    tick();
  endtask : send
  task automatic recv(input logic mack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low = 1'b0;
      tick();
      rise();
      b[i] = sda;
      scl_low = 1'b1;
      tick();
    end
    sda_low = mack;
    tick();
    rise();
    scl_low = 1'b1;
    tick();
  endtask : recv
  task automatic stop();
    sda_low = 1'b1;
    tick();
    rise();
    sda_low = 1'b0;
    tick();
  endtask : stop
endmodule : i2c_host_model
`default_nettype wire

// File: ctrl_channel_addr_gpio_test.sv
// Self-checking bench for the serializer and deserializer builds of the block.
// Assumes host model on the local bus; bench answers relay requests.
`timescale 1ns/1ps
`default_nettype none
module ctrl_channel_addr_gpio_test;
  logic clock = 1'b0, reset_n = 1'b0, link_clk = 1'b0, osc_ref_mode = 1'b0;
  logic relay_done = 1'b0, relay_ack = 1'b0;
  logic [7:0] relay_rdata = 8'h00, des_addr;
  logic [1:0] des_low = 2'h0, des_high = 2'h0;
  logic [3:0] des_fwd, des_out, des_oe;
  logic scl_oe_d, sda_oe_d, relay_read;
  logic [2:0] ser_address_strap = 3'h0;
  logic [3:0] link_gpio_in = 4'h0, gpio_in = 4'h0;
  logic scl_oe, sda_oe, relay_valid, relay_first, relay_stop, pass_through_on;
  logic scl_low, sda_low;
  logic [7:0] relay_data, own_write_addr;
  logic [3:0] gpio_out, gpio_oe;
  wire logic scl = !(scl_low || scl_oe || scl_oe_d);
  wire logic sda = !(sda_low || sda_oe || sda_oe_d);
  int fail_count = 0, n_checks = 0, relays = 0, stops = 0;
  always #2 clock = ~clock;
  always #32 link_clk = ~link_clk;
  always @(posedge clock) begin
    if (relay_valid) relays <= relays + 1;
    if (relay_stop) stops <= stops + 1;
  end
  ctrl_channel_addr_gpio #(.IS_DES(1'b0), .GPIO_COUNT(4)) uut (
    .clock, .reset_n, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(),
    .sda_oe, .ser_address_strap, .des_address_strap_low(2'h0),
    .des_address_strap_high(2'h0), .osc_ref_mode, .relay_valid, .relay_data,
    .relay_first, .relay_read, .relay_stop, .relay_done, .relay_ack,
    .relay_rdata, .link_clk, .link_gpio_in, .link_gpio_out(), .gpio_in,
    .gpio_out, .gpio_oe, .own_write_addr, .pass_through_on);
  i2c_host_model host (.clock, .scl, .sda, .scl_low, .sda_low);
  // Deserializer build on the same local bus, pass-through left off
  ctrl_channel_addr_gpio #(.IS_DES(1'b1), .GPIO_COUNT(4)) uut_des (
    .clock, .reset_n, .scl_in(scl), .scl_out(), .scl_oe(scl_oe_d), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe_d), .ser_address_strap(3'h0),
    .des_address_strap_low(des_low), .des_address_strap_high(des_high), .osc_ref_mode,
    .relay_valid(), .relay_data(), .relay_first(), .relay_read(), .relay_stop(),
    .relay_done(1'b0), .relay_ack(1'b0), .relay_rdata(8'h00), .link_clk,
    .link_gpio_in(4'h0), .link_gpio_out(des_fwd), .gpio_in, .gpio_out(des_out),
    .gpio_oe(des_oe), .own_write_addr(des_addr), .pass_through_on());
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic ack;
    host.send(b, ack);
    check(8'(ack), 8'(exp_ack));
  endtask : xfer
  task automatic wr_reg(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    host.start();
    xfer(dev, 1'b1);
    xfer(ptr, 1'b1);
    xfer(d, 1'b1);
    host.stop();
  endtask : wr_reg
  // Slow remote answer to one relay request
  task automatic answer(input logic [7:0] d, input logic f, input logic a);
    for (int i = 0; i < 4000 && relay_valid !== 1'b1; i++) @(negedge clock);
    check(relay_data, d);
    check(8'(relay_first), 8'(f));
    check(8'(relay_read), 8'h0);
    repeat (20) @(negedge clock);
    check(8'(scl), 8'h0);
    relay_ack = a;
    relay_done = 1'b1;
    @(negedge clock);
    relay_done = 1'b0;
  endtask : answer
  ////////////////////////////////////////
  task automatic t_strap();
    for (int i = 0; i < 8; i++) begin
      ser_address_strap = 3'(i);
      repeat (4) @(negedge clock);
      check(own_write_addr, {7'h58 + 7'(i > 5 ? 5 : i), 1'b0});
    end
    ser_address_strap = 3'h0;
    repeat (4) @(negedge clock);
  endtask : t_strap
  task automatic t_off();
    host.start();
    xfer(8'ha0, 1'b0);
    host.stop();
    check(8'(relays), 8'h0);
  endtask : t_off
  task automatic t_des();
    for (int i = 0; i < 16; i++) begin
      {des_high, des_low} = 4'(i);
      repeat (4) @(negedge clock);
      check(des_addr, {7'h60 + 7'(i), 1'b0});
    end
    {des_high, des_low} = 4'h0;
    repeat (4) @(negedge clock);
    wr_reg(8'hc0, 8'h01, 8'h0f);
    wr_reg(8'hc0, 8'h02, 8'h05);
    gpio_in = 4'ha;
    repeat (40) @(negedge clock);
    check(8'(des_oe), 8'h05);
    check(8'(des_out), 8'h0f);
    check(8'(des_fwd), 8'h0a);
  endtask : t_des
  task automatic t_relay();
    logic [7:0] rd;
    wr_reg(8'hb0, 8'h00, 8'h01);
    check(8'(pass_through_on), 8'h1);
    host.start();
    fork
      xfer(8'ha0, 1'b1);
      answer(8'ha0, 1'b1, 1'b1);
    join
    fork
      xfer(8'h3c, 1'b1);
      answer(8'h3c, 1'b0, 1'b1);
    join
    host.stop();
    repeat (8) @(negedge clock);
    check(8'(stops), 8'h1);
    host.start();
    fork
      xfer(8'ha2, 1'b0);
      answer(8'ha2, 1'b1, 1'b0);
    join
    host.stop();
    repeat (8) @(negedge clock);
    check(8'(stops), 8'h2);
    host.start();
    fork
      begin
        xfer(8'ha1, 1'b1);
        host.recv(1'b0, rd);
      end
      begin
        answer(8'ha1, 1'b1, 1'b1);
        for (int i = 0; i < 4000 && relay_valid !== 1'b1; i++) @(negedge clock);
        check(8'(relay_read), 8'h1);
        relay_rdata = 8'h5a;
        relay_done = 1'b1;
        @(negedge clock);
        relay_done = 1'b0;
      end
    join
    check(rd, 8'h5a);
    host.stop();
    repeat (8) @(negedge clock);
    check(8'(stops), 8'h3);
  endtask : t_relay
  task automatic t_gpio();
    link_gpio_in = 4'h8;
    wr_reg(8'hb0, 8'h01, 8'h0f);
    wr_reg(8'hb0, 8'h02, 8'h05);
    repeat (6) @(negedge clock);
    check(8'(gpio_out), 8'h0d);
    check(8'(gpio_oe), 8'h0f);
  endtask : t_gpio
  task automatic t_osc();
    logic b;
    gpio_in = 4'h6;
    osc_ref_mode = 1'b1;
    repeat (6) @(negedge clock);
    check(8'(gpio_oe), 8'h07);
    b = gpio_out[2];
    for (int i = 0; i < 3; i++) begin
      gpio_in[3] = 1'b1;
      repeat (6) @(negedge clock);
      gpio_in[3] = 1'b0;
      repeat (6) @(negedge clock);
    end
    check(8'(gpio_out[2]), {7'h00, ~b});
    check(8'(des_oe), 8'h0d);
    check(8'(des_fwd), 8'h02);
  endtask : t_osc
  ////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_strap();
    t_off();
    t_des();
    t_relay();
    t_gpio();
    t_osc();
    stop_test();
  end
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule : ctrl_channel_addr_gpio_test
`default_nettype wire
